// ===== core/fdchp_decode.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_decode
	import fdchp_pkg::*;
(
	input  wire fdchp_pins_t pins_i,
	input  wire logic        dma_mode_i,
	output fdchp_access_t    acc_o
);
	logic sel;

	always_comb begin
		// dma cycle selects the data register without chip select
		sel = !pins_i.cs_n || (dma_mode_i && !pins_i.dma_grant_low);
		acc_o = '0;
		if (sel) begin
			acc_o.illegal   = !pins_i.rd_n && !pins_i.wr_n;
			acc_o.rd_status = !pins_i.port_select && !pins_i.rd_n && pins_i.wr_n;
			acc_o.rd_data   = (pins_i.port_select || !pins_i.dma_grant_low)
				&& !pins_i.rd_n && pins_i.wr_n;
			acc_o.wr_data   = (pins_i.port_select || !pins_i.dma_grant_low)
				&& pins_i.rd_n && !pins_i.wr_n;
		end
	end
endmodule : fdchp_decode
`default_nettype wire

// ===== core/fdchp_port.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_port
	import fdchp_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       cs_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       port_select_i,
	input  wire logic       dma_grant_low_n_i,
	input  wire logic       dma_last_byte_i,
	input  wire logic [7:0] data_i,
	input  wire logic       dma_mode_i,
	input  wire logic       write_cmd_i,
	input  wire logic [3:0] cmd_len_i,
	input  wire logic [3:0] res_len_i,
	input  wire logic       core_byte_valid_i,
	input  wire logic [7:0] core_byte_i,
	input  wire logic [7:0] result_status_zero_i,
	input  wire logic [7:0] result_status_one_i,
	input  wire logic [7:0] result_status_two_i,
	input  wire logic [7:0] result_status_three_i,
	output logic [7:0]      data_o,
	output logic            data_oe_o,
	output logic            dma_request_line_o,
	output logic            int_o,
	output logic [7:0]      main_status_o,
	output logic            cmd_byte_valid_o,
	output logic [7:0]      cmd_byte_o,
	output logic            exec_byte_taken_o,
	output logic            illegal_access_o,
	output logic            abort_o
);
	typedef struct packed {
		fdchp_phase_t phase;
		logic [3:0]   count;
		logic [3:0]   res_len;
		logic         byte_pend;
		logic [7:0]   hold;
		logic [7:0]   data_out;
		logic         data_oe;
		logic         dma_request_line;
		logic         intr;
		logic         res_int;
		logic         prev_rd;
		logic         prev_wr;
		logic         prev_tc;
		logic         cmd_valid;
		logic [7:0]   cmd_byte;
		logic         exec_taken;
		logic         illegal;
		logic         abort;
		logic [7:0]   msr;
	} fdchp_state_t;

	fdchp_pins_t   pins_raw;
	fdchp_pins_t   pins;
	fdchp_access_t acc;
	logic [7:0]    data_s1_q;
	logic [7:0]    data_s2_q;
	fdchp_state_t  st_q;
	fdchp_state_t  st_d;
	logic          rd_rise;
	logic          wr_rise;
	logic          rd_fall;
	logic          tc_rise;

	function automatic logic [7:0] fdchp_msr(input logic ready, input logic dir,
		input logic exec, input logic busy);
		logic [7:0] m;
		m = 8'h00;
		m[MSR_READY_BIT] = ready;
		m[MSR_DIR_BIT]   = dir;
		m[MSR_EXEC_BIT]  = exec;
		m[MSR_BUSY_BIT]  = busy;
		return m;
	endfunction : fdchp_msr

	function automatic logic [7:0] fdchp_result(input logic [3:0] idx,
		input logic [7:0] s0, input logic [7:0] s1, input logic [7:0] s2,
		input logic [7:0] s3, input logic [7:0] pend);
		logic [7:0] r;
		unique case (idx)
			4'h0: r = s0;
			4'h1: r = s1;
			4'h2: r = s2;
			4'h3: r = s3;
			default: r = pend;
		endcase
		return r;
	endfunction : fdchp_result

	assign pins_raw = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
		port_select: port_select_i, dma_grant_low: dma_grant_low_n_i,
		dma_last_byte: dma_last_byte_i};

	fdchp_sync u_sync (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.pins_i    (pins_raw),
		.pins_o    (pins)
	);

	fdchp_decode u_decode (
		.pins_i     (pins),
		.dma_mode_i (dma_mode_i),
		.acc_o      (acc)
	);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_s1_q <= DATA_RESET;
			data_s2_q <= DATA_RESET;
		end else begin
			data_s1_q <= data_i;
			data_s2_q <= data_s1_q;
		end
	end

	// access completes on strobe release
	assign rd_fall = acc.rd_data && !st_q.prev_rd;
	assign rd_rise = !acc.rd_data && st_q.prev_rd;
	assign wr_rise = !acc.wr_data && st_q.prev_wr;
	assign tc_rise = pins.dma_last_byte && !st_q.prev_tc;

	always_comb begin
		st_d            = st_q;
		st_d.prev_rd    = acc.rd_data;
		st_d.prev_wr    = acc.wr_data;
		st_d.prev_tc    = pins.dma_last_byte;
		st_d.cmd_valid  = 1'b0;
		st_d.exec_taken = 1'b0;
		st_d.abort      = 1'b0;
		st_d.illegal    = acc.illegal;
		st_d.data_oe    = acc.rd_status || acc.rd_data;
		unique case (st_q.phase)
			FDCHP_CMD: begin
				st_d.dma_request_line  = 1'b0;
				st_d.intr = 1'b0;
				if (wr_rise) begin
					st_d.cmd_valid = 1'b1;
					st_d.cmd_byte  = data_s2_q;
					if (st_q.count == 4'h0) begin
						st_d.res_len = res_len_i;
					end
					if (st_q.count + 4'h1 >= cmd_len_i) begin
						st_d.phase     = FDCHP_EXEC;
						st_d.count     = 4'h0;
						st_d.byte_pend = 1'b0;
					end else begin
						st_d.count = st_q.count + 4'h1;
					end
				end
			end
			FDCHP_EXEC: begin
				if (core_byte_valid_i && !st_q.byte_pend) begin
					st_d.byte_pend = 1'b1;
					st_d.hold      = core_byte_i;
				end
				if (st_q.byte_pend) begin
					if (dma_mode_i) begin
						st_d.intr = 1'b0;
						st_d.dma_request_line  = pins.dma_grant_low;
					end else begin
						st_d.dma_request_line  = 1'b0;
						st_d.intr = 1'b1;
					end
					if ((!write_cmd_i && rd_rise) || (write_cmd_i && wr_rise)) begin
						st_d.byte_pend  = 1'b0;
						st_d.intr       = 1'b0;
						st_d.dma_request_line        = 1'b0;
						st_d.exec_taken = 1'b1;
						if (write_cmd_i) begin
							st_d.cmd_byte = data_s2_q;
						end
					end
					if (!pins.dma_grant_low) begin
						st_d.dma_request_line = 1'b0;
					end
				end else begin
					st_d.dma_request_line  = 1'b0;
					st_d.intr = 1'b0;
				end
				if (tc_rise) begin
					st_d.phase     = FDCHP_RES;
					st_d.dma_request_line       = 1'b0;
					st_d.intr      = 1'b1;
					st_d.res_int   = 1'b1;
					st_d.byte_pend = 1'b0;
					st_d.count     = 4'h0;
				end
			end
			FDCHP_RES: begin
				if (rd_rise) begin
					st_d.intr    = 1'b0;
					st_d.res_int = 1'b0;
					if (st_q.count + 4'h1 >= st_q.res_len) begin
						st_d.phase = FDCHP_CMD;
						st_d.count = 4'h0;
					end else begin
						st_d.count = st_q.count + 4'h1;
					end
				end
			end
			FDCHP_IDLE: begin
				st_d.phase = FDCHP_CMD;
			end
			default: begin
				st_d.phase = FDCHP_CMD;
			end
		endcase
		if (tc_rise && st_q.phase == FDCHP_CMD && st_q.count != 4'h0) begin
			st_d.phase = FDCHP_CMD;
			st_d.count = 4'h0;
			st_d.abort = 1'b1;
		end
		if (tc_rise && st_q.phase == FDCHP_EXEC) begin
			st_d.abort = 1'b1;
		end
		if (acc.rd_status) begin
			st_d.data_out = st_q.msr;
		end else if (acc.rd_data && rd_fall) begin
			if (st_q.phase == FDCHP_RES) begin
				st_d.data_out = fdchp_result(st_q.count, result_status_zero_i,
					result_status_one_i, result_status_two_i,
					result_status_three_i, st_q.hold);
			end else begin
				st_d.data_out = st_q.hold;
			end
		end
		unique case (st_d.phase)
			FDCHP_CMD: st_d.msr = fdchp_msr(1'b1, 1'b0, 1'b0, st_d.count != 4'h0);
			FDCHP_EXEC: st_d.msr = fdchp_msr(st_d.byte_pend && !dma_mode_i,
				!write_cmd_i, 1'b1, 1'b1);
			FDCHP_RES: st_d.msr = fdchp_msr(1'b1, 1'b1, 1'b0, 1'b1);
			default: st_d.msr = fdchp_msr(1'b0, 1'b0, 1'b0, 1'b0);
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q       <= '0;
			st_q.phase <= FDCHP_IDLE;
			st_q.msr   <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end

	assign data_o             = st_q.data_out;
	assign data_oe_o          = st_q.data_oe;
	assign dma_request_line_o = st_q.dma_request_line;
	assign int_o              = st_q.intr;
	assign main_status_o      = st_q.msr;
	assign cmd_byte_valid_o   = st_q.cmd_valid;
	assign cmd_byte_o         = st_q.cmd_byte;
	assign exec_byte_taken_o  = st_q.exec_taken;
	assign illegal_access_o   = st_q.illegal;
	assign abort_o            = st_q.abort;
endmodule : fdchp_port
`default_nettype wire

// ===== core/fdchp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_sync
	import fdchp_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire fdchp_pins_t pins_i,
	output fdchp_pins_t      pins_o
);
	typedef struct packed {
		fdchp_pins_t s1;
		fdchp_pins_t s2;
	} fdchp_sync_state_t;

	localparam fdchp_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		port_select: 1'b0, dma_grant_low: 1'b1, dma_last_byte: 1'b0};

	fdchp_sync_state_t st_q;
	fdchp_sync_state_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = pins_i;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= '{s1: PINS_IDLE, s2: PINS_IDLE};
		end else begin
			st_q <= st_d;
		end
	end

	assign pins_o = st_q.s2;
endmodule : fdchp_sync
`default_nettype wire

// ===== inc/fdchp_pkg.sv
package fdchp_pkg;

	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned BYTE_PERIOD_NS   = 13000;
	localparam int unsigned BYTE_PERIOD_CYC  = BYTE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned CMD_COUNT        = 15;
	localparam int unsigned MAX_BYTES        = 9;

	localparam int unsigned MSR_READY_BIT    = 7;
	localparam int unsigned MSR_DIR_BIT      = 6;
	localparam int unsigned MSR_EXEC_BIT     = 5;
	localparam int unsigned MSR_BUSY_BIT     = 4;

	localparam logic [3:0]  CMD_LEN_DEFAULT  = 4'h9;
	localparam logic [3:0]  RES_LEN_DEFAULT  = 4'h7;
	localparam logic [7:0]  DATA_RESET       = 8'h00;

	typedef enum logic [3:0] {
		FDCHP_CMD  = 4'b0001,
		FDCHP_EXEC = 4'b0010,
		FDCHP_RES  = 4'b0100,
		FDCHP_IDLE = 4'b1000
	} fdchp_phase_t;

	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       port_select;
		logic       dma_grant_low;
		logic       dma_last_byte;
	} fdchp_pins_t;

	typedef struct packed {
		logic rd_status;
		logic rd_data;
		logic wr_data;
		logic illegal;
	} fdchp_access_t;

endpackage : fdchp_pkg

// ===== tb/fdchp_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_dma_model
	import fdchp_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       req_i,
	input  wire logic       write_cmd_i,
	input  wire logic [3:0] dly_i,
	output var logic        grant_n_o,
	output var logic        rd_n_o,
	output var logic        wr_n_o
);
	initial {grant_n_o, rd_n_o, wr_n_o} = 3'b111;
	always begin
		@(negedge ref_clk_i);
		if (resetn_i && req_i) begin
			repeat (dly_i) @(negedge ref_clk_i);
			grant_n_o = 0;
			rd_n_o = write_cmd_i;
			wr_n_o = !write_cmd_i;
			repeat (4) @(negedge ref_clk_i);
			{rd_n_o, wr_n_o} = 2'b11;
			@(negedge ref_clk_i);
			grant_n_o = 1;
			repeat (4) @(negedge ref_clk_i);
		end
	end
endmodule : fdchp_dma_model
`default_nettype wire

// ===== tb/fdchp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_port_monitor
	import fdchp_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       resetn_i,
	input wire logic       cs_n_i,
	input wire logic       rd_n_i,
	input wire logic       wr_n_i,
	input wire logic       port_select_i,
	input wire logic       dma_grant_low_n_i,
	input wire logic       dma_last_byte_i,
	input wire logic       dma_mode_i,
	input wire logic       int_o,
	input wire logic       dma_request_line_o,
	input wire logic [7:0] main_status_o,
	input wire logic       cmd_byte_valid_o,
	input wire logic       data_oe_o,
	input wire logic       illegal_access_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rd_done;
		!cs_n_i && port_select_i && !rd_n_i ##1 rd_n_i;
	endsequence
	sequence s_unselected;
		(cs_n_i && dma_grant_low_n_i) [*6];
	endsequence
	a_reset_quiet: assert property ($rose(resetn_i) |-> !int_o && !dma_request_line_o)
		else $error("output active after reset");
	a_select_gate: assert property (s_unselected |-> !cmd_byte_valid_o && !data_oe_o)
		else $error("access while deselected");
	a_illegal_flag: assert property ((!cs_n_i && !rd_n_i && !wr_n_i) [*5] |-> illegal_access_o)
		else $error("illegal combination not flagged");
	a_dma_only_req: assert property (!dma_mode_i |-> !dma_request_line_o)
		else $error("request outside dma mode");
	a_grant_clears: assert property ($fell(dma_grant_low_n_i) |-> ##[1:4] !dma_request_line_o)
		else $error("request kept after grant");
	a_tc_result: assert property ($rose(dma_last_byte_i) && main_status_o[5]
		|-> ##[1:6] (int_o && main_status_o == 8'hd0))
		else $error("no result phase after count");
	a_first_clear: assert property (s_rd_done ##0 (int_o && main_status_o[7:5] == 3'b110)
		|-> ##[1:5] !int_o)
		else $error("result interrupt kept");
	a_back_ready: assert property ($fell(main_status_o[4]) |-> main_status_o == 8'h80)
		else $error("not ready after command");
endmodule : fdchp_port_monitor
bind fdchp_port fdchp_port_monitor i_mon (.*);
`default_nettype wire

// ===== tb/fdchp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_port_tb
	import fdchp_pkg::*;
;
	typedef struct packed {
		logic dma; logic wc; logic [3:0] cl; logic [3:0] rl; logic [7:0] b; logic [7:0] e;
	} fdchp_row_t;
	fdchp_row_t rows [4] = '{'{0, 0, 9, 7, 8'h5a, 8'h5a}, '{1, 0, 2, 7, 8'ha5, 8'ha5},
		'{0, 1, 3, 4, 8'h3c, 8'h3c}, '{1, 1, 1, 1, 8'hc3, 8'hc3}};
	logic       ref_clk_i = 0, resetn_i = 0, cs_n = 1, h_rd = 1, h_wr = 1;
	logic       ps = 0, tc = 0, dma = 0, wcmd = 0, cv = 0;
	logic [7:0] din = 0, cb = 0, rdv, dout, cbyte, msr;
	logic [7:0] st [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	logic [3:0] clen = 1, rlen = 1, dly = 0;
	logic       gnt_n, p_rd, p_wr, oe, dma_request_out, intr, cval, taken, ill, abrt;
	logic       oe_seen = 0, abrt_seen = 0;
	int         failures = 0, checks = 0, cyc = 0;
	fdchp_port i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
		.rd_n_i(h_rd & p_rd), .wr_n_i(h_wr & p_wr), .port_select_i(ps),
		.dma_grant_low_n_i(gnt_n), .dma_last_byte_i(tc), .data_i(din), .dma_mode_i(dma),
		.write_cmd_i(wcmd), .cmd_len_i(clen), .res_len_i(rlen), .core_byte_valid_i(cv),
		.core_byte_i(cb), .result_status_zero_i(st[0]), .result_status_one_i(st[1]),
		.result_status_two_i(st[2]), .result_status_three_i(st[3]), .data_o(dout),
		.data_oe_o(oe), .dma_request_line_o(dma_request_out), .int_o(intr), .main_status_o(msr),
		.cmd_byte_valid_o(cval), .cmd_byte_o(cbyte), .exec_byte_taken_o(taken),
		.illegal_access_o(ill), .abort_o(abrt));
	fdchp_dma_model i_dma (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(dma_request_out),
		.write_cmd_i(wcmd), .dly_i(dly), .grant_n_o(gnt_n), .rd_n_o(p_rd), .wr_n_o(p_wr));
	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wt(input int s);
		for (int n = 0; n < 200; n++) begin
			@(negedge ref_clk_i);
			if ((s == 0 && intr) || (s == 1 && dma_request_out) || (s == 2 && taken))
				return;
		end
		chk("wait", 1, 0);
	endtask : wt
	task automatic acc(input logic a, input logic r, input logic w, input logic [7:0] d);
		@(negedge ref_clk_i);
		cs_n = 0;
		ps = a;
		h_rd = r;
		h_wr = w;
		din = d;
		repeat (4) @(negedge ref_clk_i);
		rdv = dout;
		oe_seen = oe;
		{h_rd, h_wr} = 2'b11;
		repeat (4) @(negedge ref_clk_i);
		cs_n = 1;
		repeat (2) @(negedge ref_clk_i);
	endtask : acc
	task automatic run(input fdchp_row_t r);
		dma = r.dma;
		wcmd = r.wc;
		clen = r.cl;
		rlen = r.rl;
		for (int i = 0; i < r.cl; i++) begin
			acc(0, 0, 1, 0);
			chk("cmd ready", 8'h80, rdv & 8'hc0);
			chk("read enable", 1, oe_seen);
			acc(1, 1, 0, 8'h10 + i[7:0]);
			chk("cmd byte", 8'h10 + i[7:0], cbyte);
			chk("write enable", 0, oe_seen);
		end
		chk("exec", 8'h20, msr & 8'h20);
		cb = r.b;
		din = r.b;
		cv = 1;
		@(negedge ref_clk_i);
		cv = 0;
		if (r.dma) begin
			wt(1);
			chk("dma int", 0, intr);
			wt(2);
			repeat (2) @(negedge ref_clk_i);
			chk("req drop", 0, dma_request_out);
		end else begin
			wt(0);
			chk("poll", 8'h80, msr & 8'h80);
			acc(1, r.wc, !r.wc, r.b);
			chk("int clr", 0, intr);
		end
		chk("exec byte", r.e, r.wc ? cbyte : dout);
		tc = 1;
		repeat (6) @(negedge ref_clk_i);
		tc = 0;
		chk("res msr", 8'hd0, msr);
		chk("res int", 1, intr);
		for (int i = 0; i < r.rl; i++) begin
			if (i == r.rl - 1) begin
				acc(1, 1, 0, 8'hee);
				chk("refused", 8'hc0, msr & 8'hc0);
			end
			acc(0, 0, 1, 0);
			chk("res ready", 8'hc0, rdv & 8'hc0);
			acc(1, 0, 1, 0);
			chk("res byte", i < 4 ? st[i] : r.b, rdv);
			chk("res int", 0, intr);
		end
		chk("done", 8'h80, msr);
	endtask : run
	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(negedge ref_clk_i);
		resetn_i = 1;
		repeat (4) @(negedge ref_clk_i);
		chk("reset msr", 8'h80, msr);
		for (int t = 0; t < 4; t++) begin
			dly = {1'b0, rows[t].wc, 2'b11};
			run(rows[t]);
			$display("test %0d done", t);
		end
		ps = 1;
		h_wr = 0;
		repeat (6) @(negedge ref_clk_i);
		h_wr = 1;
		repeat (6) @(negedge ref_clk_i);
		chk("deselected", 8'h80, msr);
		ps = 0;
		cs_n = 0;
		{h_rd, h_wr} = 2'b00;
		repeat (6) @(negedge ref_clk_i);
		chk("illegal", 1, ill);
		{h_rd, h_wr} = 2'b11;
		repeat (4) @(negedge ref_clk_i);
		cs_n = 1;
		clen = 3;
		acc(1, 1, 0, 8'h01);
		tc = 1;
		for (int n = 0; n < 6; n++) begin
			@(negedge ref_clk_i);
			if (abrt)
				abrt_seen = 1;
		end
		tc = 0;
		chk("abort", 8'h80, msr);
		chk("abort pulse", 1, abrt_seen);
		acc(1, 1, 0, 8'h01);
		resetn_i = 0;
		@(negedge ref_clk_i);
		chk("in reset", 0, {msr[7:1], intr});
		@(negedge ref_clk_i);
		resetn_i = 1;
		repeat (4) @(negedge ref_clk_i);
		chk("after reset", 8'h80, msr);
		$display("test hand done");
		end_sim();
	end
endmodule : fdchp_port_tb
`default_nettype wire
